/* File: inc/spd_cfg.svh */
// register offsets, field positions, reset values and timing counts
`ifndef SPD_CFG_SVH
`define SPD_CFG_SVH
`define A_STATUS 6'h00
`define A_CMD 6'h01
`define A_NETREF 6'h02
`define A_NETMON 6'h03
`define A_RATED 6'h04
`define A_MINF 6'h05
`define A_MAXF 6'h06
`define A_LSEL 6'h07
`define A_RSEL 6'h08
`define A_BACKUP 6'h09
`define A_REFOUT 6'h0A
`define A_FN0 6'h0C
`define A_MS0 6'h10
`define CB_RAMP_EN 0
`define CB_GEN_EN 1
`define CB_FWD 2
`define CB_JOG 3
`define CB_REMOTE 4
`define CB_RAMP2 5
`define SB_RAMP2 5
`define SB_CONFIG_INCOMPATIBILITY_STATE 6
`define SB_ALARM 7
`define SB_RUN 8
`define SB_ENA 9
`define SB_FWD 10
`define SB_JOG 11
`define SB_REMOTE 12
`define SB_UV 13
`define SB_FAULT 15
`define SEL_EPOT 4'h7
`define SEL_MSPEED 4'h8
`define FN_INC_A 8'h0B
`define FN_INC_B 8'h21
`define FN_DEC_A 8'h0C
`define FN_DEC_B 8'h22
`define FN_MSPEED 8'h0D
`define SCALE_SHIFT 13
`define MON_MAX 16'h7FFF
`define RST_CMD 16'h0000
`define RST_RATED 16'h0258
`define RST_MINF 16'h001E
`define RST_MAXF 16'h0294
`define RST_BACKUP 2'h1
`define CLK_MHZ 40
`define EPOT_STEP_US 1000
`define EPOT_STEP_CYC (`EPOT_STEP_US * `CLK_MHZ)
`endif

/* File: inc/spd_pkg.sv */
// shared types of the speed reference and status block
package spd_pkg;
   typedef enum logic [2:0] {
      SRC_NET = 3'b001,
      SRC_EPOT = 3'b010,
      SRC_MULTI = 3'b100
   } src_t;
   typedef logic [15:0] word_t;
   typedef logic signed [19:0] wide_ref_t;
endpackage

/* File: hw/epot_ref.sv */
// electronic potentiometer reference with saturating steps
`timescale 1ns/1ps
module epot_ref
   import spd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic step_en,
   input wire logic active,
   input wire logic inc,
   input wire logic dec,
   input wire logic clear,
   input wire logic load_min,
   input wire word_t min_lim,
   input wire word_t max_lim,
   output word_t value_q
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         value_q <= 16'h0000;
      end else if (clear) begin
         value_q <= 16'h0000;
      end else if (load_min) begin
         value_q <= min_lim;
      end else if (active && step_en) begin
         // a lowered limit pulls the value back in without wrapping
         if (value_q > max_lim) begin
            value_q <= max_lim;
         end else if (inc && !dec && value_q < max_lim) begin
            value_q <= value_q + 16'h0001;
         end else if (dec && !inc && value_q > min_lim) begin
            value_q <= value_q - 16'h0001;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   epot_clear_a: assert property (clear |=> value_q == 16'h0000)
      else $error("potentiometer not cleared");
   epot_up_a: assert property (
      active && step_en && inc && !dec && !clear && !load_min && value_q < max_lim
      |=> value_q == $past(value_q) + 16'h0001)
      else $error("potentiometer did not step up");
   epot_sat_a: assert property (
      active && step_en && !clear && !load_min && value_q == max_lim && !dec
      |=> value_q == $past(max_lim))
      else $error("potentiometer passed the upper limit");
endmodule

/* File: hw/speed_ref_status.sv */
// speed reference selection, scaling and inverter status word
`timescale 1ns/1ps
`include "spd_cfg.svh"
module speed_ref_status
   import spd_pkg::*;
#(
   parameter int EPOT_STEP_CYC = `EPOT_STEP_CYC
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic [5:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [3:0] PIN_IN,
   input wire logic ALARM_IN,
   input wire logic FAULT_IN,
   input wire logic UNDERVOLT_IN,
   input wire logic RUNNING_IN,
   output logic [15:0] RDATA,
   output logic [15:0] STATUS_WORD,
   output logic [15:0] REF_OUT,
   output logic FWD_OUT,
   output logic ENABLE_OUT,
   output logic CONFIG_INCOMPATIBILITY_STATE_OUT
);
   ////////////////////////////////////////////////////////////////////////////
   // software registers
   word_t cmd_q;
   word_t net_ref_q;
   word_t rated_q;
   word_t min_q;
   word_t max_q;
   logic [3:0] lsel_q;
   logic [3:0] rsel_q;
   logic [1:0] backup_q;
   logic [7:0] fn_q [4];
   word_t ms_q [8];
   word_t monitor_q;

   // the status offset is left out on purpose: writes there change nothing
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         cmd_q <= `RST_CMD;
         net_ref_q <= 16'h0000;
         rated_q <= `RST_RATED;
         min_q <= `RST_MINF;
         max_q <= `RST_MAXF;
         lsel_q <= 4'h0;
         rsel_q <= 4'h0;
         backup_q <= `RST_BACKUP;
      end else if (WR) begin
         unique case (ADDR)
            `A_CMD: cmd_q <= WDATA;
            `A_NETREF: net_ref_q <= WDATA;
            `A_RATED: rated_q <= WDATA;
            `A_MINF: min_q <= WDATA;
            `A_MAXF: max_q <= WDATA;
            `A_LSEL: lsel_q <= WDATA[3:0];
            `A_RSEL: rsel_q <= WDATA[3:0];
            `A_BACKUP: backup_q <= WDATA[1:0];
            default: ;
         endcase
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_fn
         always_ff @(posedge CLK or negedge RESETN) begin
            if (!RESETN) begin
               fn_q[g] <= 8'h00;
            end else if (WR && ADDR == 6'(`A_FN0 + g)) begin
               fn_q[g] <= WDATA[7:0];
            end
         end
      end
      for (g = 0; g < 8; g++) begin : g_ms
         always_ff @(posedge CLK or negedge RESETN) begin
            if (!RESETN) begin
               ms_q[g] <= 16'h0000;
            end else if (WR && ADDR == 6'(`A_MS0 + g)) begin
               ms_q[g] <= WDATA;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // digital input pins
   logic [3:0] pin_meta_q;
   logic [3:0] pin_q;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         pin_meta_q <= 4'h0;
         pin_q <= 4'h0;
      end else begin
         pin_meta_q <= PIN_IN;
         pin_q <= pin_meta_q;
      end
   end

   logic [3:0] is_inc;
   logic [3:0] is_dec;
   logic [3:0] is_ms;
   generate
      for (g = 0; g < 4; g++) begin : g_role
         assign is_inc[g] = fn_q[g] == `FN_INC_A || fn_q[g] == `FN_INC_B;
         assign is_dec[g] = fn_q[g] == `FN_DEC_A || fn_q[g] == `FN_DEC_B;
         assign is_ms[g] = fn_q[g] == `FN_MSPEED;
      end
   endgenerate

   logic config_incompatibility_state;
   logic [2:0] ms_idx;
   logic up_in;
   logic dn_in;
   // pins one and two both compete for the most significant bit
   assign config_incompatibility_state = is_ms[0] && is_ms[1];
   assign ms_idx = {(is_ms[0] & pin_q[0]) | (is_ms[1] & pin_q[1]),
                    is_ms[2] & pin_q[2], is_ms[3] & pin_q[3]};
   assign up_in = |(pin_q & is_inc);
   assign dn_in = |(pin_q & is_dec);

   ////////////////////////////////////////////////////////////////////////////
   // enable and potentiometer
   logic enabled;
   logic ena_q;
   logic [3:0] sel;
   src_t src;
   assign enabled = cmd_q[`CB_GEN_EN] && !config_incompatibility_state;
   assign sel = cmd_q[`CB_REMOTE] ? rsel_q : lsel_q;

   always_comb begin
      if (sel == `SEL_EPOT) begin
         src = SRC_EPOT;
      end else if (sel == `SEL_MSPEED) begin
         src = SRC_MULTI;
      end else begin
         src = SRC_NET;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ena_q <= 1'b0;
      end else begin
         ena_q <= enabled;
      end
   end

   logic [15:0] step_cnt_q;
   logic step_en;
   assign step_en = step_cnt_q == 16'h0000;

   // steps are slow on purpose: one tenth of a hertz per period
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         step_cnt_q <= 16'h0000;
      end else if (step_en) begin
         step_cnt_q <= 16'(EPOT_STEP_CYC - 1);
      end else begin
         step_cnt_q <= step_cnt_q - 16'h0001;
      end
   end

   word_t epot_val;
   epot_ref u_epot (
      .clk(CLK),
      .rst_n(RESETN),
      .step_en(step_en),
      .active(src == SRC_EPOT),
      .inc(up_in),
      .dec(dn_in),
      .clear(!enabled && up_in && dn_in),
      .load_min(enabled && !ena_q && backup_q == 2'h0),
      .min_lim(min_q),
      .max_lim(max_q),
      .value_q(epot_val)
   );

   ////////////////////////////////////////////////////////////////////////////
   // reference scaling and clamp
   logic signed [32:0] net_prod;
   wide_ref_t raw;
   logic [19:0] mag;
   word_t ref_d;
   logic fwd_d;

   // 8192 counts of the network scale equal the rated frequency
   assign net_prod = $signed(net_ref_q) * $signed({1'b0, rated_q});

   always_comb begin
      unique case (src)
         SRC_EPOT: raw = {4'h0, epot_val};
         SRC_MULTI: raw = {{4{ms_q[ms_idx][15]}}, ms_q[ms_idx]};
         SRC_NET: raw = net_prod[32:`SCALE_SHIFT];
      endcase
   end

   assign mag = raw[19] ? 20'(-raw) : 20'(raw);
   assign fwd_d = cmd_q[`CB_FWD] ^ raw[19];

   always_comb begin
      if (mag > {4'h0, max_q}) begin
         ref_d = max_q;
      end else if (mag < {4'h0, min_q}) begin
         ref_d = min_q;
      end else begin
         ref_d = mag[15:0];
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         REF_OUT <= 16'h0000;
         FWD_OUT <= 1'b0;
         ENABLE_OUT <= 1'b0;
         CONFIG_INCOMPATIBILITY_STATE_OUT <= 1'b0;
      end else begin
         REF_OUT <= ref_d;
         FWD_OUT <= fwd_d;
         ENABLE_OUT <= enabled;
         CONFIG_INCOMPATIBILITY_STATE_OUT <= config_incompatibility_state;
      end
   end

   // monitor back into the network scale; a zero rating reads zero
   logic [28:0] mon_num;
   logic [28:0] mon_quo;
   word_t mon_mag;
   assign mon_num = {REF_OUT, 13'h0000};
   assign mon_quo = (rated_q == 16'h0000) ? 29'h0000 : mon_num / {13'h0000, rated_q};
   assign mon_mag = (mon_quo > {13'h0000, `MON_MAX}) ? `MON_MAX : mon_quo[15:0];

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         monitor_q <= 16'h0000;
      end else begin
         monitor_q <= FWD_OUT ? mon_mag : 16'(-mon_mag);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status word
   word_t status_d;
   always_comb begin
      status_d = 16'h0000;
      status_d[`SB_RAMP2] = cmd_q[`CB_RAMP2];
      status_d[`SB_CONFIG_INCOMPATIBILITY_STATE] = config_incompatibility_state;
      status_d[`SB_ALARM] = ALARM_IN;
      status_d[`SB_RUN] = RUNNING_IN;
      status_d[`SB_ENA] = enabled;
      status_d[`SB_FWD] = fwd_d;
      status_d[`SB_JOG] = cmd_q[`CB_JOG];
      status_d[`SB_REMOTE] = cmd_q[`CB_REMOTE];
      status_d[`SB_UV] = UNDERVOLT_IN;
      status_d[`SB_FAULT] = FAULT_IN;
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         STATUS_WORD <= 16'h0000;
      end else begin
         STATUS_WORD <= status_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register read port
   word_t rd_d;
   always_comb begin
      rd_d = 16'h0000;
      if (ADDR >= `A_MS0 && ADDR < 6'(`A_MS0 + 8)) begin
         rd_d = ms_q[ADDR[2:0]];
      end else if (ADDR >= `A_FN0 && ADDR < 6'(`A_FN0 + 4)) begin
         rd_d = {8'h00, fn_q[ADDR[1:0]]};
      end else begin
         unique case (ADDR)
            `A_STATUS: rd_d = STATUS_WORD;
            `A_CMD: rd_d = cmd_q;
            `A_NETREF: rd_d = net_ref_q;
            `A_NETMON: rd_d = monitor_q;
            `A_RATED: rd_d = rated_q;
            `A_MINF: rd_d = min_q;
            `A_MAXF: rd_d = max_q;
            `A_LSEL: rd_d = {12'h000, lsel_q};
            `A_RSEL: rd_d = {12'h000, rsel_q};
            `A_BACKUP: rd_d = {14'h0000, backup_q};
            `A_REFOUT: rd_d = REF_OUT;
            default: rd_d = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         RDATA <= 16'h0000;
      end else begin
         RDATA <= RD ? rd_d : 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   status_ro_a: assert property (
      WR && ADDR == `A_STATUS |=> cmd_q == $past(cmd_q) && max_q == $past(max_q))
      else $error("status write changed a register");
   config_incompatibility_state_state_a: assert property (
      is_ms[0] && is_ms[1] |=> CONFIG_INCOMPATIBILITY_STATE_OUT && STATUS_WORD[`SB_CONFIG_INCOMPATIBILITY_STATE])
      else $error("double msb did not raise config state");
   enable_refused_a: assert property (CONFIG_INCOMPATIBILITY_STATE_OUT |-> !ENABLE_OUT && !STATUS_WORD[`SB_ENA])
      else $error("enabled while in config state");
   reserved_zero_a: assert property (STATUS_WORD[4:0] == 5'h00 && !STATUS_WORD[14])
      else $error("reserved status bits set");
   ramp_bit_a: assert property (
      WR && ADDR == `A_CMD ##1 !(WR && ADDR == `A_CMD)
      |=> STATUS_WORD[`SB_RAMP2] == $past(WDATA[`CB_RAMP2], 2))
      else $error("second ramp bit wrong");
   ref_clamp_a: assert property (
      RESETN && min_q <= max_q |=> REF_OUT <= $past(max_q) && REF_OUT >= $past(min_q))
      else $error("reference outside limits");
   ms_sign_a: assert property (
      src == SRC_MULTI && ms_q[ms_idx][15] |=> FWD_OUT == !$past(cmd_q[`CB_FWD]))
      else $error("negative multispeed did not reverse");
   ms_pick_a: assert property (
      src == SRC_MULTI && mag_in_range(ms_q[ms_idx], min_q, max_q)
      |=> REF_OUT == $past(ms_q[ms_idx][15] ? 16'(-ms_q[ms_idx]) : ms_q[ms_idx]))
      else $error("wrong multispeed reference taken");
   net_scale_a: assert property (
      src == SRC_NET && net_ref_q == 16'h2000 && rated_q >= min_q && rated_q <= max_q
      |=> REF_OUT == $past(rated_q) && FWD_OUT == $past(cmd_q[`CB_FWD]))
      else $error("8192 did not map to rated frequency");
   flags_a: assert property (
      RESETN |=> STATUS_WORD[`SB_ALARM] == $past(ALARM_IN)
      && STATUS_WORD[`SB_FAULT] == $past(FAULT_IN))
      else $error("alarm or fault flag wrong");

   function automatic logic mag_in_range(word_t v, word_t lo, word_t hi);
      word_t m;
      m = v[15] ? 16'(-v) : v;
      return m >= lo && m <= hi;
   endfunction

   epot_cov_c: cover property (src == SRC_EPOT && up_in && step_en);
   ms_cov_c: cover property (src == SRC_MULTI && ms_idx == 3'h7);
   config_incompatibility_state_cov_c: cover property (CONFIG_INCOMPATIBILITY_STATE_OUT && cmd_q[`CB_GEN_EN]);
endmodule

/* File: tb/far_side.sv */
// model of the network controller and digital input field beside the block
`timescale 1ns/1ps
module far_side (
   input wire logic clk,
   output logic [5:0] addr,
   output logic [15:0] wdata,
   output logic wr,
   output logic rd,
   input wire logic [15:0] rdata,
   output logic [3:0] pins,
   output logic [3:0] stat
);
   initial begin
      addr = 6'h00;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
      pins = 4'h0;
      stat = 4'h0;
   end
   ////////////////////////////////////////////////////////////
   // one idle edge after each strobe, so a strobe is never set twice in one step
   task automatic put(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic get(input logic [5:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // switch levels and drive conditions, s = {running, undervoltage, fault, alarm}
   task automatic set_in(input logic [3:0] p, input logic [3:0] s);
      @(posedge clk);
      pins <= p;
      stat <= s;
   endtask
   // the controller speaks the 13-bit scale, rated frequency reads 8192
   function automatic logic [15:0] to_net(input int hz10, input int rated);
      return 16'((hz10 * 8192) / rated);
   endfunction
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the speed reference and status block
`timescale 1ns/1ps
`include "spd_cfg.svh"
module tb_top;
   import spd_pkg::*;
   // a non-zero word is read last so the one-cycle read data check can fail
   localparam logic [5:0] RA [8] = '{`A_STATUS, 6'h0B, 6'h3F, `A_CMD, `A_MINF, `A_MAXF,
      `A_BACKUP, `A_RATED};
   localparam logic [15:0] RV [8] = '{16'h0000, 16'h0000, 16'h0000, `RST_CMD, `RST_MINF,
      `RST_MAXF, {14'h0000, `RST_BACKUP}, `RST_RATED};
   localparam logic [15:0] MS [8] = '{16'h0000, 16'h002D, 16'hFF38, 16'h1388, 16'h000A,
      16'hFD44, 16'h014D, 16'h0294};
   logic clk;
   logic rst_n;
   logic [5:0] addr;
   logic [15:0] wdata;
   logic wr;
   logic rd;
   logic [3:0] pins;
   logic [3:0] stat;
   logic [15:0] rdata;
   logic [15:0] sw;
   logic [15:0] ref_o;
   logic fwd;
   logic ena;
   logic config_incompatibility_state;
   int fails;
   int checks;
   speed_ref_status #(.EPOT_STEP_CYC(4)) i_dut (.CLK(clk), .RESETN(rst_n), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .PIN_IN(pins), .ALARM_IN(stat[0]), .FAULT_IN(stat[1]),
      .UNDERVOLT_IN(stat[2]), .RUNNING_IN(stat[3]), .RDATA(rdata), .STATUS_WORD(sw),
      .REF_OUT(ref_o), .FWD_OUT(fwd), .ENABLE_OUT(ena), .CONFIG_INCOMPATIBILITY_STATE_OUT(config_incompatibility_state));
   far_side i_far (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .pins(pins), .stat(stat));
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   function automatic logic [15:0] exp_st(input logic [15:0] c, input logic [3:0] s,
      input logic f);
      logic [15:0] e;
      e = 16'h0000;
      e[`SB_RAMP2] = c[`CB_RAMP2];
      e[`SB_ALARM] = s[0];
      e[`SB_RUN] = s[3];
      e[`SB_ENA] = c[`CB_GEN_EN];
      e[`SB_FWD] = f;
      e[`SB_JOG] = c[`CB_JOG];
      e[`SB_REMOTE] = c[`CB_REMOTE];
      e[`SB_UV] = s[2];
      e[`SB_FAULT] = s[1];
      return e;
   endfunction
   function automatic logic [15:0] exp_ref(input int v);
      int m;
      m = (v < 0) ? -v : v;
      if (m < int'(`RST_MINF)) m = int'(`RST_MINF);
      if (m > int'(`RST_MAXF)) m = int'(`RST_MAXF);
      return 16'(m);
   endfunction
   function automatic int net_hz(input logic [15:0] n);
      return (int'($signed(n)) * int'(`RST_RATED)) >>> 13;
   endfunction
   function automatic logic [15:0] exp_mon(input logic [15:0] r, input logic f);
      int m;
      m = int'(r) * 8192 / int'(`RST_RATED);
      if (m > 32767) m = 32767;
      return f ? 16'(m) : 16'(-m);
   endfunction
   ////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // the run needs about 13000 cycles; this allows roughly three times that
   initial begin
      #1000000;
      fails++;
      close_out();
   end
   initial begin
      logic [15:0] d;
      logic [15:0] c;
      logic [15:0] n;
      logic [3:0] s;
      logic [3:0] up;
      logic [3:0] dn;
      rst_n = 1'b0;
      fails = 0;
      checks = 0;
      void'($urandom(32'h7bd4_7050));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         i_far.get(RA[i], d);
         chk(d, RV[i]);
      end
      @(posedge clk);
      #1 chk(rdata, 16'h0000);
      chk(ref_o, `RST_MINF);
      $display("test reset values done");
      for (int i = 0; i < 16; i++) begin
         c = 16'($urandom) & 16'h003F;
         s = 4'($urandom);
         i_far.set_in(4'h0, s);
         i_far.put(`A_CMD, c);
         if (i[0]) i_far.put(`A_STATUS, 16'hFFFF);
         repeat (3) @(posedge clk);
         #1 chk(sw, exp_st(c, s, c[`CB_FWD]));
         chk({15'h0000, ena}, {15'h0000, c[`CB_GEN_EN]});
         i_far.get(`A_STATUS, d);
         chk(d, exp_st(c, s, c[`CB_FWD]));
      end
      $display("test status word done");
      i_far.set_in(4'h0, 4'h0);
      i_far.put(`A_CMD, 16'h0006);
      for (int i = 0; i < 8; i++) begin
         n = (i < 4) ? i_far.to_net(600 - 300 * i, 600) : 16'($urandom);
         if (i == 3) n = 16'h0064;
         i_far.put(`A_NETREF, n);
         repeat (4) @(posedge clk);
         #1 chk(ref_o, exp_ref(net_hz(n)));
         chk({15'h0000, fwd}, {15'h0000, ~n[15]});
         i_far.get(`A_NETMON, d);
         chk(d, exp_mon(exp_ref(net_hz(n)), ~n[15]));
      end
      $display("test network scale done");
      i_far.put(`A_LSEL, {12'h000, `SEL_MSPEED});
      for (int k = 0; k < 8; k++) begin
         i_far.put(`A_MS0 + 6'(k), MS[k]);
         if (k != 1 && k < 4) i_far.put(`A_FN0 + 6'(k), {8'h00, `FN_MSPEED});
      end
      for (int k = 0; k < 8; k++) begin
         i_far.set_in({k[0], k[1], 1'b0, k[2]}, 4'h0);
         repeat (5) @(posedge clk);
         #1 chk(ref_o, exp_ref(int'($signed(MS[k]))));
         chk({15'h0000, fwd}, {15'h0000, ~MS[k][15]});
      end
      i_far.put(`A_FN0 + 6'h01, {8'h00, `FN_MSPEED});
      repeat (4) @(posedge clk);
      #1 chk({13'h0000, config_incompatibility_state, sw[`SB_CONFIG_INCOMPATIBILITY_STATE], ena}, 16'h0006);
      i_far.put(`A_FN0 + 6'h01, 16'h0000);
      repeat (4) @(posedge clk);
      #1 chk({13'h0000, config_incompatibility_state, sw[`SB_CONFIG_INCOMPATIBILITY_STATE], ena}, 16'h0001);
      $display("test multispeed done");
      i_far.set_in(4'h0, 4'h0);
      i_far.put(`A_LSEL, {12'h000, `SEL_EPOT});
      for (int j = 0; j < 2; j++) begin
         up = j ? 4'b0100 : 4'b0001;
         dn = j ? 4'b1000 : 4'b0010;
         i_far.put(`A_FN0, j ? 16'h0000 : {8'h00, `FN_INC_A});
         i_far.put(`A_FN0 + 6'h01, j ? 16'h0000 : {8'h00, `FN_DEC_B});
         i_far.put(`A_FN0 + 6'h02, j ? {8'h00, `FN_INC_B} : 16'h0000);
         i_far.put(`A_FN0 + 6'h03, j ? {8'h00, `FN_DEC_A} : 16'h0000);
         i_far.set_in(up, 4'h0);
         repeat (3000) @(posedge clk);
         #1 chk(ref_o, `RST_MAXF);
         i_far.set_in(dn, 4'h0);
         repeat (40) @(posedge clk);
         #1 chk(16'(ref_o < `RST_MAXF && ref_o > 16'h0280), 16'h0001);
         repeat (3000) @(posedge clk);
         #1 chk(ref_o, `RST_MINF);
         i_far.set_in(up, 4'h0);
         repeat (100) @(posedge clk);
         i_far.set_in(4'h0, 4'h0);
         repeat (4) @(posedge clk);
         #1 chk(16'(ref_o > `RST_MINF), 16'h0001);
         i_far.put(`A_CMD, 16'h0004);
         i_far.set_in(up | dn, 4'h0);
         repeat (8) @(posedge clk);
         i_far.set_in(4'h0, 4'h0);
         i_far.put(`A_CMD, 16'h0006);
         repeat (6) @(posedge clk);
         #1 chk(ref_o, `RST_MINF);
      end
      // remote selector picks the potentiometer; backup mode 0 restarts it at the minimum
      i_far.put(`A_NETREF, 16'h0000);
      i_far.put(`A_RSEL, {12'h000, `SEL_EPOT});
      i_far.put(`A_LSEL, 16'h0000);
      i_far.put(`A_CMD, 16'h0016);
      i_far.set_in(4'b0100, 4'h0);
      repeat (200) @(posedge clk);
      i_far.set_in(4'h0, 4'h0);
      repeat (4) @(posedge clk);
      #1 chk(16'(ref_o > `RST_MINF), 16'h0001);
      i_far.put(`A_BACKUP, 16'h0000);
      i_far.put(`A_CMD, 16'h0014);
      i_far.put(`A_CMD, 16'h0016);
      repeat (4) @(posedge clk);
      #1 chk(ref_o, `RST_MINF);
      $display("test potentiometer done");
      close_out();
   end
endmodule
